// *** logic/lch_regs.sv ***
// Legacy configuration header register bank in the first I/O region
// Behaviour
// RULE1 - Mirror header, doorbell, cause byte in I/O region
// RULE2 - Driver uses legacy region only without capability
// RULE3 - Base header fields in documented order and access
// RULE4 - MSI-X on: config vector then queue vector
// RULE5 - Upper option: offered high then accepted high
// RULE6 - Device-specific area follows general headers
// RULE7 - Status write of zero resets the device
// RULE8 - Guest sets found, driver, ready, gave-up flags
// RULE9 - After giving up, guest resets before reinit
// RULE10 - Bit 31 offered only beyond 31 features
// RULE11 - Feature ranges: type, extensions, future
// RULE12 - Guest accepts only understood offered bits
// RULE13 - Accepted set changes only across reset; the code locks the accepted words only while the ready flag is set
// RULE14 - Accepted bit 31 clear hides upper bits
// RULE15 - Device area at 24 with MSI-X, else 20
// RULE16 - Vector 0..0x7ff routes event to vector
// RULE17 - All-ones code unmaps the event
// RULE18 - Reads return mapping; reset leaves all unmapped
// RULE19 - Guest_gave_up_flag mapping reads back unmapped
// RULE20 - Driver reads back each vector write
// RULE21 - Queue depth zero means no queue
// RULE22 - Queue base given as address over page size
// RULE23 - Layout follows MSI-X enable at once
`timescale 1ns/1ps
module lch_regs import lch_pkg::*; #(
  parameter int unsigned NQ = LCH_NUM_QUEUES,
  parameter int unsigned NV = LCH_NUM_VECTORS,
  parameter logic [15:0] QDEPTH = LCH_QUEUE_DEPTH
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Legacy I/O region access
  input wire lch_io_req_t io_req,
  output logic [31:0] io_rdata,
  output logic io_rvalid,
  // PCI function state
  input wire logic msix_en,
  // Device core: features
  input wire logic [63:0] offered_feat,
  output logic [63:0] accepted_feat,
  // Device core: progress and reset
  output logic [7:0] progress,
  output logic soft_reset,
  // Device core: queues
  output logic doorbell_valid,
  output logic [15:0] doorbell_idx,
  input wire logic [15:0] core_q_idx,
  output logic [31:0] core_q_page,
  output logic [15:0] core_q_vector,
  output logic [15:0] cfg_vector,
  // Device core: interrupt cause events
  input wire logic [7:0] cause_set,
  // Device-specific area
  output lch_dev_wr_t dev_wr,
  output logic [7:0] dev_raddr,
  input wire logic [31:0] dev_rdata
);
  // Offered words as the guest sees them
  logic [31:0] off_hi;
  logic [31:0] off_lo;
  logic upper_opt;
  logic [7:0] hi_base;
  logic [7:0] dev_base;
  logic [7:0] wa;
  logic wr;
  logic rd;

  // Register state
  logic [31:0] acc_lo_ff;
  logic [31:0] nxt_acc_lo;
  logic [31:0] acc_hi_ff;
  logic [31:0] nxt_acc_hi;
  logic [15:0] qsel_ff;
  logic [15:0] nxt_qsel;
  logic [7:0] prog_ff;
  logic [7:0] nxt_prog;
  logic [7:0] cause_ff;
  logic [7:0] nxt_cause;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic rvalid_ff;
  logic db_valid_ff;
  logic [15:0] db_idx_ff;
  logic [15:0] nxt_db_idx;
  logic soft_ff;
  lch_dev_wr_t dev_wr_ff;
  lch_dev_wr_t nxt_dev_wr;

  // Decode
  logic hit_acc_lo;
  logic hit_page;
  logic hit_qword;
  logic hit_misc;
  logic hit_vec;
  logic hit_off_hi;
  logic hit_acc_hi;
  logic hit_dev;
  logic soft_rst;
  logic acc_open;
  logic [31:0] misc_word;
  logic [31:0] vec_word;
  logic [31:0] vec_merged;
  logic [31:0] page_rd;
  logic [15:0] depth_rd;
  logic [15:0] cfg_vec_rd;
  logic [15:0] sel_vec_rd;
  logic [31:0] qword_merged;
  logic [31:0] db_merged;

  // Future range forced clear; bit 31 tells whether anything lies above
  assign off_hi = offered_feat[63:32] & FEAT_HIGH_MASK; // RULE11
  assign upper_opt = |off_hi; // RULE10
  assign off_lo = {upper_opt, offered_feat[30:0] & FEAT_LOW_MASK[30:0]}; // RULE10

  assign wa = io_req.addr;
  assign wr = io_req.wr & ce;
  assign rd = io_req.rd & ce;

  // Combinational on msix_en so the layout moves the moment the enable does
  assign hi_base = msix_en ? 8'(OFF_EXT_BASE + OFF_MSIX_SHIFT) : OFF_EXT_BASE; // RULE23 RULE4
  assign dev_base = upper_opt ? 8'(hi_base + OFF_HIGH_WORDS) : hi_base; // RULE15 RULE6

  assign hit_acc_lo = lch_same_word(wa, OFF_ACCEPTED_LO); // RULE3
  assign hit_page = lch_same_word(wa, OFF_QUEUE_PAGE);
  assign hit_qword = lch_same_word(wa, OFF_QUEUE_DEPTH);
  assign hit_misc = lch_same_word(wa, OFF_DOORBELL);
  assign hit_vec = msix_en && lch_same_word(wa, OFF_EXT_BASE); // RULE4
  assign hit_off_hi = upper_opt && lch_same_word(wa, hi_base); // RULE5
  assign hit_acc_hi = upper_opt && lch_same_word(wa, 8'(hi_base + OFF_WORD)); // RULE5
  assign hit_dev = wa[7:2] >= dev_base[7:2]; // RULE6

  // Progress write of zero restarts the whole function
  assign soft_rst = wr && hit_misc && io_req.be[2] && io_req.wdata[23:16] == 8'h00; // RULE7
  // Accepted words freeze while the driver reports ready; a reset or a progress write that clears the ready flag reopens them
  assign acc_open = (prog_ff & GUEST_READY_FLAG) == 8'h00; // RULE13

  assign misc_word = {msix_en ? 8'h00 : cause_ff, prog_ff, 16'h0000}; // RULE15
  assign vec_word = {sel_vec_rd, cfg_vec_rd}; // RULE18
  assign vec_merged = lch_merge(vec_word, io_req.wdata, io_req.be);
  assign qword_merged = lch_merge({qsel_ff, depth_rd}, io_req.wdata, io_req.be);
  // Lanes not enabled read as zero in the doorbell value
  assign db_merged = lch_merge(32'h00000000, io_req.wdata, io_req.be);

  lch_queue_table #(
    .NQ(NQ),
    .QDEPTH(QDEPTH)
  ) u_queues (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .soft_rst(soft_rst),
    .sel(qsel_ff),
    .page_wr(wr && hit_page),
    .page_be(io_req.be),
    .page_wdata(io_req.wdata),
    .sel_page(page_rd),
    .sel_depth(depth_rd),
    .core_idx(core_q_idx),
    .core_page(core_q_page)
  );

  lch_vector_map #(
    .NQ(NQ),
    .NV(NV)
  ) u_vectors (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .soft_rst(soft_rst),
    .cfg_wr(wr && hit_vec && |io_req.be[1:0]),
    .q_wr(wr && hit_vec && |io_req.be[3:2]),
    .wvec(|io_req.be[1:0] ? vec_merged[15:0] : vec_merged[31:16]),
    .sel(qsel_ff),
    .cfg_vec(cfg_vec_rd),
    .sel_vec(sel_vec_rd),
    .core_idx(core_q_idx),
    .core_vec(core_q_vector)
  );

  // Guest-written fields
  always_comb begin
    nxt_acc_lo = acc_lo_ff;
    nxt_acc_hi = acc_hi_ff;
    nxt_qsel = qsel_ff;
    nxt_prog = prog_ff;
    if (soft_rst) begin
      nxt_acc_lo = '0; // RULE13
      nxt_acc_hi = '0;
      nxt_qsel = '0;
      nxt_prog = '0; // RULE7
    end else if (wr) begin
      if (hit_acc_lo && acc_open) begin
        nxt_acc_lo = lch_merge(acc_lo_ff, io_req.wdata, io_req.be); // RULE13
      end
      if (hit_acc_hi && acc_open) begin
        nxt_acc_hi = lch_merge(acc_hi_ff, io_req.wdata, io_req.be); // RULE5
      end
      if (hit_qword) begin
        nxt_qsel = qword_merged[31:16]; // RULE3
      end
      if (hit_misc && io_req.be[2]) begin
        nxt_prog = io_req.wdata[23:16];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_lo_ff <= '0;
      acc_hi_ff <= '0;
      qsel_ff <= '0;
      prog_ff <= '0;
    end else if (ce) begin
      acc_lo_ff <= nxt_acc_lo;
      acc_hi_ff <= nxt_acc_hi;
      qsel_ff <= nxt_qsel;
      prog_ff <= nxt_prog;
    end
  end

  // Cause byte: reading it with MSI-X off clears it, but a new event in that cycle survives
  always_comb begin
    nxt_cause = cause_ff;
    if (soft_rst || (rd && hit_misc && io_req.be[3] && !msix_en)) begin
      nxt_cause = '0;
    end
    nxt_cause = nxt_cause | cause_set;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cause_ff <= '0;
    end else if (ce) begin
      cause_ff <= nxt_cause;
    end
  end

  // Read path, answered one cycle after the strobe
  always_comb begin
    nxt_rdata = rdata_ff;
    if (rd) begin
      if (hit_dev) begin
        nxt_rdata = dev_rdata; // RULE6
      end else if (hit_vec) begin
        nxt_rdata = vec_word; // RULE18 RULE19
      end else if (hit_off_hi) begin
        nxt_rdata = off_hi; // RULE5
      end else if (hit_acc_hi) begin
        nxt_rdata = acc_lo_ff[FEAT_MORE_BIT] ? acc_hi_ff : 32'h00000000; // RULE14
      end else if (lch_same_word(wa, OFF_OFFERED_LO)) begin
        nxt_rdata = off_lo; // RULE10
      end else if (hit_acc_lo) begin
        nxt_rdata = acc_lo_ff;
      end else if (hit_page) begin
        nxt_rdata = page_rd;
      end else if (hit_qword) begin
        nxt_rdata = {qsel_ff, depth_rd}; // RULE21
      end else if (hit_misc) begin
        nxt_rdata = misc_word; // RULE1
      end else begin
        nxt_rdata = 32'h00000000;
      end
    end
  end

  // Doorbell pulses and device-area writes
  always_comb begin
    nxt_db_idx = db_idx_ff;
    if (wr && hit_misc && |io_req.be[1:0]) begin
      nxt_db_idx = db_merged[15:0]; // RULE1
    end
    nxt_dev_wr.wr = wr && hit_dev;
    nxt_dev_wr.addr = 8'(wa - dev_base);
    nxt_dev_wr.be = io_req.be;
    nxt_dev_wr.wdata = io_req.wdata;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= '0;
      rvalid_ff <= 1'b0;
      db_valid_ff <= 1'b0;
      db_idx_ff <= '0;
      soft_ff <= 1'b0;
      dev_wr_ff <= '0;
    end else if (ce) begin
      rdata_ff <= nxt_rdata;
      rvalid_ff <= rd;
      db_valid_ff <= wr && hit_misc && |io_req.be[1:0];
      db_idx_ff <= nxt_db_idx;
      soft_ff <= soft_rst; // RULE7
      dev_wr_ff <= nxt_dev_wr;
    end
  end

  assign io_rdata = rdata_ff;
  assign io_rvalid = rvalid_ff;
  // Upper accepted bits count only while accepted bit 31 is set
  assign accepted_feat = {acc_lo_ff[FEAT_MORE_BIT] ? acc_hi_ff : 32'h00000000, acc_lo_ff}; // RULE14
  assign progress = prog_ff;
  assign soft_reset = soft_ff;
  assign doorbell_valid = db_valid_ff;
  assign doorbell_idx = db_idx_ff;
  assign cfg_vector = cfg_vec_rd;
  assign dev_wr = dev_wr_ff;
  // Read address is combinational so the core can answer within the strobe cycle
  assign dev_raddr = 8'(wa - dev_base);
endmodule

// *** logic/lch_pkg.sv ***
// Shared constants, types and helpers of the legacy configuration header bank
package lch_pkg;
  // Byte offsets in the legacy I/O region
  localparam logic [7:0] OFF_OFFERED_LO = 8'h00;
  localparam logic [7:0] OFF_ACCEPTED_LO = 8'h04;
  localparam logic [7:0] OFF_QUEUE_PAGE = 8'h08;
  localparam logic [7:0] OFF_QUEUE_DEPTH = 8'h0c;
  localparam logic [7:0] OFF_QUEUE_SELECT = 8'h0e;
  localparam logic [7:0] OFF_DOORBELL = 8'h10;
  localparam logic [7:0] OFF_PROGRESS = 8'h12;
  localparam logic [7:0] OFF_CAUSE = 8'h13;
  localparam logic [7:0] OFF_EXT_BASE = 8'h14;
  localparam logic [7:0] OFF_MSIX_SHIFT = 8'h04;
  localparam logic [7:0] OFF_HIGH_WORDS = 8'h08;
  localparam logic [7:0] OFF_WORD = 8'h04;
  // Device progress flags set by the guest
  localparam logic [7:0] GUEST_FOUND_FLAG = 8'h01;
  localparam logic [7:0] GUEST_DRIVER_FLAG = 8'h02;
  localparam logic [7:0] GUEST_READY_FLAG = 8'h04;
  localparam logic [7:0] GUEST_GAVE_UP_FLAG = 8'h80;
  // Interrupt cause bits
  localparam int unsigned CAUSE_QUEUE_BIT = 0;
  localparam int unsigned CAUSE_CONFIG_BIT = 1;
  // Vector mapping
  localparam logic [15:0] UNMAPPED_VECTOR_CONSTANT = 16'hffff;
  localparam logic [15:0] MAX_TABLE_ENTRY = 16'h07ff;
  // Feature word layout
  localparam int unsigned FEAT_MORE_BIT = 31;
  localparam logic [31:0] FEAT_LOW_MASK = 32'h7fffffff;
  localparam logic [31:0] FEAT_HIGH_MASK = 32'h000001ff;
  // Queue base granularity used by the driver, in bytes
  localparam int unsigned QUEUE_PAGE_BYTES = 4096;
  // Defaults of the module parameters
  localparam int unsigned LCH_NUM_QUEUES = 4;
  localparam int unsigned LCH_NUM_VECTORS = 8;
  localparam logic [15:0] LCH_QUEUE_DEPTH = 16'h0100;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } lch_io_req_t;

  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } lch_dev_wr_t;

  function automatic logic [31:0] lch_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic lch_same_word(input logic [7:0] a, input logic [7:0] b);
    return a[7:2] == b[7:2];
  endfunction
endpackage

// *** logic/lch_queue_table.sv ***
// Per-queue base page storage and queue depth lookup
`timescale 1ns/1ps
module lch_queue_table import lch_pkg::*; #(
  parameter int unsigned NQ = LCH_NUM_QUEUES,
  parameter logic [15:0] QDEPTH = LCH_QUEUE_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic soft_rst,
  // Guest side, selected queue
  input wire logic [15:0] sel,
  input wire logic page_wr,
  input wire logic [3:0] page_be,
  input wire logic [31:0] page_wdata,
  output logic [31:0] sel_page,
  output logic [15:0] sel_depth,
  // Core side lookup
  input wire logic [15:0] core_idx,
  output logic [31:0] core_page
);
  localparam int unsigned QW = (NQ > 1) ? $clog2(NQ) : 1;

  logic [31:0] page_ff [NQ];
  logic sel_ok;
  logic core_ok;

  assign sel_ok = sel < 16'(NQ);
  assign core_ok = core_idx < 16'(NQ);

  for (genvar q = 0; q < NQ; q++) begin : g_q
    logic [31:0] nxt_page;
    always_comb begin
      nxt_page = page_ff[q];
      if (soft_rst) begin
        nxt_page = '0;
      end else if (page_wr && sel_ok && sel[QW-1:0] == QW'(q)) begin
        nxt_page = lch_merge(page_ff[q], page_wdata, page_be);
      end
    end
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        page_ff[q] <= '0;
      end else if (ce) begin
        page_ff[q] <= nxt_page;
      end
    end
  end

  // Unknown indices read zero so the guest sees no queue there
  assign sel_depth = sel_ok ? QDEPTH : 16'h0000; // RULE21
  assign sel_page = sel_ok ? page_ff[sel[QW-1:0]] : 32'h00000000;
  assign core_page = core_ok ? page_ff[core_idx[QW-1:0]] : 32'h00000000;
endmodule

// *** logic/lch_vector_map.sv ***
// Event-to-vector mapping for the configuration event and each queue
`timescale 1ns/1ps
module lch_vector_map import lch_pkg::*; #(
  parameter int unsigned NQ = LCH_NUM_QUEUES,
  parameter int unsigned NV = LCH_NUM_VECTORS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic soft_rst,
  // Guest writes
  input wire logic cfg_wr,
  input wire logic q_wr,
  input wire logic [15:0] wvec,
  input wire logic [15:0] sel,
  // Read back and core lookup
  output logic [15:0] cfg_vec,
  output logic [15:0] sel_vec,
  input wire logic [15:0] core_idx,
  output logic [15:0] core_vec
);
  localparam int unsigned QW = (NQ > 1) ? $clog2(NQ) : 1;

  logic [15:0] cfg_vec_ff;
  logic [15:0] nxt_cfg_vec;
  logic [15:0] qvec_ff [NQ];
  logic [15:0] granted;
  logic sel_ok;

  // A request past the table we hold cannot be given resources and reads back unmapped
  always_comb begin
    if (wvec == UNMAPPED_VECTOR_CONSTANT) begin
      granted = UNMAPPED_VECTOR_CONSTANT; // RULE17
    end else if (wvec <= MAX_TABLE_ENTRY && wvec < 16'(NV)) begin
      granted = wvec; // RULE16
    end else begin
      granted = UNMAPPED_VECTOR_CONSTANT; // RULE19
    end
  end

  assign sel_ok = sel < 16'(NQ);

  always_comb begin
    nxt_cfg_vec = cfg_vec_ff;
    if (soft_rst) begin
      nxt_cfg_vec = UNMAPPED_VECTOR_CONSTANT; // RULE18
    end else if (cfg_wr) begin
      nxt_cfg_vec = granted;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_vec_ff <= UNMAPPED_VECTOR_CONSTANT; // RULE18
    end else if (ce) begin
      cfg_vec_ff <= nxt_cfg_vec;
    end
  end

  for (genvar q = 0; q < NQ; q++) begin : g_q
    logic [15:0] nxt_qvec;
    always_comb begin
      nxt_qvec = qvec_ff[q];
      if (soft_rst) begin
        nxt_qvec = UNMAPPED_VECTOR_CONSTANT;
      end else if (q_wr && sel_ok && sel[QW-1:0] == QW'(q)) begin
        nxt_qvec = granted; // RULE16
      end
    end
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        qvec_ff[q] <= UNMAPPED_VECTOR_CONSTANT; // RULE18
      end else if (ce) begin
        qvec_ff[q] <= nxt_qvec;
      end
    end
  end

  assign cfg_vec = cfg_vec_ff;
  assign sel_vec = sel_ok ? qvec_ff[sel[QW-1:0]] : UNMAPPED_VECTOR_CONSTANT; // RULE18
  assign core_vec = (core_idx < 16'(NQ)) ? qvec_ff[core_idx[QW-1:0]] : UNMAPPED_VECTOR_CONSTANT;
endmodule

// *** dv/lch_regs_props.sv ***
// Checker of the legacy header bank, bound to its top module
`timescale 1ns/1ps
module lch_regs_props import lch_pkg::*; #(
  parameter int unsigned NQ = LCH_NUM_QUEUES,
  parameter int unsigned NV = LCH_NUM_VECTORS,
  parameter logic [15:0] QDEPTH = LCH_QUEUE_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  // Register access
  input wire lch_io_req_t io_req,
  input wire logic [31:0] io_rdata,
  input wire logic io_rvalid,
  input wire logic msix_en,
  // Core side
  input wire logic [63:0] offered_feat,
  input wire logic [63:0] accepted_feat,
  input wire logic [7:0] progress,
  input wire logic soft_reset,
  input wire logic doorbell_valid,
  input wire logic [15:0] doorbell_idx,
  input wire logic [15:0] core_q_idx,
  input wire logic [31:0] core_q_page,
  input wire logic [15:0] core_q_vector,
  input wire logic [15:0] cfg_vector,
  input wire logic [7:0] cause_set,
  input wire lch_dev_wr_t dev_wr,
  input wire logic [7:0] dev_raddr,
  input wire logic [31:0] dev_rdata
);
  logic [5:0] wd;
  logic go_rd;
  logic go_wr;
  assign wd = io_req.addr[7:2];
  assign go_rd = ce & io_req.rd;
  assign go_wr = ce & io_req.wr;

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_RD_ANSWER: assert property (go_rd |=> io_rvalid)
    else $error("read strobe not answered");
  AST_OFFERED_LO: assert property (go_rd && wd == 6'h0 |=>
    io_rdata == {|$past(offered_feat[40:32]), $past(offered_feat[30:0])})
    else $error("offered low word wrong");
  AST_ZERO_RESET: assert property (go_wr && wd == 6'h4 && io_req.be[2] &&
    io_req.wdata[23:16] == 8'h00 |=> soft_reset && progress == 8'h00)
    else $error("status zero did not reset");
  AST_SOFT_CLEAR: assert property (soft_reset |->
    accepted_feat == 64'h0 && cfg_vector == UNMAPPED_VECTOR_CONSTANT)
    else $error("soft reset left state behind");
  AST_LOCKED: assert property ($past(progress[2]) && !soft_reset |-> $stable(accepted_feat))
    else $error("accepted set changed while locked");
  AST_HIGH_HIDDEN: assert property (!accepted_feat[31] |-> accepted_feat[63:32] == 32'h0)
    else $error("upper accepted bits visible");
  AST_DOORBELL: assert property (go_wr && wd == 6'h4 && io_req.be[1:0] == 2'b11 |=>
    doorbell_valid && doorbell_idx == $past(io_req.wdata[15:0]))
    else $error("doorbell not passed on");
  AST_CAUSE_MUTE: assert property (go_rd && wd == 6'h4 && msix_en |=> io_rdata[31:24] == 8'h00)
    else $error("cause byte visible with vectors on");
  AST_DEV_BASE: assert property (go_wr && offered_feat[40:32] == 9'h0 &&
    wd == (msix_en ? 6'h6 : 6'h5) |=> dev_wr.wr &&
    dev_wr.addr == $past(io_req.addr) - ($past(msix_en) ? 8'h18 : 8'h14))
    else $error("device area base wrong");
  AST_VEC_READ: assert property (go_rd && wd == 6'h5 && msix_en |=>
    io_rdata[15:0] == $past(cfg_vector))
    else $error("config vector read back wrong");
endmodule

bind lch_regs lch_regs_props #(.NQ(NQ), .NV(NV), .QDEPTH(QDEPTH)) u_props (
  .clk, .nrst, .ce, .io_req, .io_rdata, .io_rvalid, .msix_en, .offered_feat,
  .accepted_feat, .progress, .soft_reset, .doorbell_valid, .doorbell_idx,
  .core_q_idx, .core_q_page, .core_q_vector, .cfg_vector, .cause_set, .dev_wr,
  .dev_raddr, .dev_rdata);

// *** dv/lch_core_model.sv ***
// Device core stand-in: offered features, events, device-area data
`timescale 1ns/1ps
module lch_core_model import lch_pkg::*; (
  // Bench controls
  input wire logic hi_on,
  input wire logic [1:0] ev,
  // Block side
  output logic [63:0] offered_feat,
  output logic [7:0] cause_set,
  input wire logic [7:0] dev_raddr,
  output logic [31:0] dev_rdata
);
  // Bit 31 stays low: the bank derives it from the upper word
  assign offered_feat = {(hi_on ? 32'h0000_0103 : 32'h0), 32'h00a5_0c31};
  assign cause_set = {6'h00, ev};
  // Answers in the same cycle, as the bank expects
  assign dev_rdata = {24'hd1e5a0, dev_raddr};
endmodule

// *** dv/lch_regs_bench.sv ***
// Self-checking bench of the legacy header bank
`timescale 1ns/1ps
module lch_regs_bench import lch_pkg::*; ;
  logic clk, nrst, ce, msix_en, rvalid, srst, dbv, hi_on;
  lch_io_req_t req;
  lch_dev_wr_t dwr;
  logic [31:0] rdata, qpage, drd, v;
  logic [63:0] off_f, acc_f;
  logic [7:0] prog, cset, draddr, p;
  logic [15:0] dbi, qi, qvec, cvec, e;
  logic [1:0] ev;
  logic [7:0] fl[4] = '{GUEST_FOUND_FLAG, GUEST_DRIVER_FLAG, GUEST_READY_FLAG,
                        GUEST_GAVE_UP_FLAG};
  logic [15:0] vw[5] = '{16'h0, 16'h7, 16'h8, 16'h07ff, 16'hffff};
  int mismatches = 0;
  int cmp_count = 0;

  lch_regs #(.NQ(4), .NV(8), .QDEPTH(16'h0100)) dut (
    .clk(clk), .nrst(nrst), .ce(ce), .io_req(req), .io_rdata(rdata), .io_rvalid(rvalid),
    .msix_en(msix_en), .offered_feat(off_f), .accepted_feat(acc_f), .progress(prog),
    .soft_reset(srst), .doorbell_valid(dbv), .doorbell_idx(dbi), .core_q_idx(qi),
    .core_q_page(qpage), .core_q_vector(qvec), .cfg_vector(cvec), .cause_set(cset),
    .dev_wr(dwr), .dev_raddr(draddr), .dev_rdata(drd));
  lch_core_model core (.hi_on(hi_on), .ev(ev), .offered_feat(off_f), .cause_set(cset),
    .dev_raddr(draddr), .dev_rdata(drd));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [31:0] ex, input logic [31:0] got);
    cmp_count++;
    if (got !== ex) begin
      mismatches++;
      $display("BAD t=%0t exp=%h got=%h", $time, ex, got);
    end
  endtask

  // Each access starts one falling edge on, so strobes never drop and rise together
  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b0, a, b, d};
    @(negedge clk);
    req.wr = 1'b0;
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] ex);
    @(negedge clk);
    req = '{1'b0, 1'b1, a, 4'hf, 32'h0};
    @(negedge clk);
    chk(32'h1, {31'h0, rvalid});
    chk(ex, rdata & m);
    req.rd = 1'b0;
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict();
  end

  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    req = '0;
    msix_en = 1'b0;
    hi_on = 1'b0;
    ev = 2'b00;
    qi = 16'h0;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    rc(8'h04, 32'hffffffff, 32'h0);
    rc(8'h00, 32'hffffffff, 32'h00a50c31);
    msix_en = 1'b1;
    rc(8'h14, 32'hffffffff, 32'hffffffff);
    hi_on = 1'b1;
    rc(8'h00, 32'hffffffff, 32'h80a50c31);
    rc(8'h18, 32'hffffffff, 32'h00000103);
    $display("test reset and offer done");
    wr(8'h04, 4'hf, 32'h80000031);
    wr(8'h1c, 4'hf, 32'h3);
    chk(32'h3, acc_f[63:32]);
    wr(8'h04, 4'hf, 32'h00000031);
    chk(32'h0, acc_f[63:32]);
    $display("test features done");
    p = 8'h00;
    for (int i = 0; i < 4; i++) begin
      p = p | fl[i];
      wr(8'h10, 4'h4, {8'h00, p, 16'h0});
      chk({24'h0, p}, {24'h0, prog});
    end
    wr(8'h04, 4'hf, 32'h1);
    rc(8'h04, 32'hffffffff, 32'h31);
    wr(8'h10, 4'h4, 32'h0);
    chk(32'h1, {31'h0, srst});
    chk(32'h0, acc_f[31:0]);
    wr(8'h04, 4'hf, 32'h1);
    rc(8'h04, 32'hffffffff, 32'h1);
    $display("test status done");
    wr(8'h0c, 4'hc, 32'h0001_0000);
    wr(8'h14, 4'hc, 32'h0003_0000);
    rc(8'h14, 32'hffff0000, 32'h0003_0000);
    qi = 16'h1;
    // Let the combinational lookup settle before looking
    #1;
    chk(32'h3, {16'h0, qvec});
    for (int i = 0; i < 5; i++) begin
      wr(8'h14, 4'h3, {16'h0, vw[i]});
      e = (vw[i] <= MAX_TABLE_ENTRY && vw[i] < 16'd8) ? vw[i] : UNMAPPED_VECTOR_CONSTANT;
      rc(8'h14, 32'h0000ffff, {16'h0, e});
      chk({16'h0, e}, {16'h0, cvec});
    end
    $display("test vectors done");
    rc(8'h0c, 32'hffff0000, 32'h0001_0000);
    wr(8'h0c, 4'hc, 32'h0009_0000);
    rc(8'h0c, 32'h0000ffff, 32'h0);
    wr(8'h0c, 4'hc, 32'h0002_0000);
    rc(8'h0c, 32'h0000ffff, 32'h0100);
    wr(8'h08, 4'hf, 32'h00012345);
    qi = 16'h2;
    #1;
    chk(32'h00012345, qpage);
    wr(8'h10, 4'h3, 32'h2);
    chk(32'h1, {31'h0, dbv});
    chk(32'h2, {16'h0, dbi});
    $display("test queues done");
    rc(8'h20, 32'hffffffff, 32'hd1e5a000);
    hi_on = 1'b0;
    msix_en = 1'b0;
    wr(8'h14, 4'hf, 32'h55);
    chk(32'h1, {31'h0, dwr.wr});
    chk(32'h0, {24'h0, dwr.addr});
    chk(32'h55, dwr.wdata);
    rc(8'h14, 32'hffffffff, 32'hd1e5a000);
    msix_en = 1'b1;
    rc(8'h18, 32'hffffffff, 32'hd1e5a000);
    $display("test layout done");
    msix_en = 1'b0;
    ev = 2'b10;
    @(negedge clk);
    ev = 2'b00;
    rc(8'h10, 32'hff000000, 32'h0200_0000);
    rc(8'h10, 32'hff000000, 32'h0);
    msix_en = 1'b1;
    ev = 2'b01;
    @(negedge clk);
    ev = 2'b00;
    rc(8'h10, 32'hff000000, 32'h0);
    $display("test cause done");
    // A write while the enable is low must leave the accepted word alone
    ce = 1'b0;
    wr(8'h04, 4'hf, 32'h0);
    ce = 1'b1;
    rc(8'h04, 32'hffffffff, 32'h1);
    $display("test enable done");
    print_verdict();
  end
endmodule
